// ### src/rsmt_params.svh
`ifndef RSMT_PARAMS_SVH
`define RSMT_PARAMS_SVH

// Register offsets on the internal register port
`define RSMT_OFS_PRE 8'h2F
`define RSMT_OFS_DATA 8'h30
`define RSMT_OFS_TMO 8'h31
`define RSMT_OFS_SLL 8'h32
`define RSMT_OFS_SLH 8'h33
`define RSMT_OFS_TCHK 8'h34

// Reset values
`define RSMT_RST_BYTE 8'h00
`define RSMT_RST_WORD 16'h0000
`define RSMT_RD_NONE 8'h00

// Field positions of the monitor control registers
`define RSMT_BIT_EXT 7
`define RSMT_BIT_RSVD 7
`define RSMT_EN_HI 6
`define RSMT_EN_LO 1
`define RSMT_BIT_ACC 0

// Field positions of the search timeout register
`define RSMT_PRESC_HI 7
`define RSMT_PRESC_LO 6
`define RSMT_CNT_HI 5
`define RSMT_CNT_LO 0

// Timeout tick period in bit periods, per prescaler code
`define RSMT_TICK_P0 7'd2
`define RSMT_TICK_P1 7'd4
`define RSMT_TICK_P2 7'd16
`define RSMT_TICK_P3 7'd64

// Prescaler codes
`define RSMT_PC_2 2'h0
`define RSMT_PC_4 2'h1
`define RSMT_PC_16 2'h2
`define RSMT_PC_64 2'h3

// Slicer byte split
`define RSMT_SL_HI 15
`define RSMT_SL_MID 8
`define RSMT_SL_LO 7

`endif

// ### src/rsmt_pkg.sv
package rsmt_pkg;

  // Receiver phase reported by the sequencer, Gray coded
  typedef enum logic [1:0] {
    RSMT_IDLE = 2'h0,
    RSMT_WAKE = 2'h1,
    RSMT_PRE = 2'h3,
    RSMT_DATA = 2'h2
  } rsmt_phase_t;

  // Register access strobes and data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsmt_regreq_t;

  // Monitor results, bit 5 chip timeout down to bit 0 amplitude
  typedef struct packed {
    logic [5:0] fail;
    logic all_pass;
  } rsmt_mon_t;

  // Whole block state
  typedef struct packed {
    logic [7:0] pre_ctrl;
    logic [7:0] data_ctrl;
    logic [7:0] tmo_ctrl;
    logic [15:0] slicer;
    logic [7:0] tchk;
    rsmt_phase_t phase_q;
    logic [6:0] presc_cnt;
    logic [5:0] tick_cnt;
    logic timer_done;
    logic [5:0] pre_acc;
    logic [5:0] data_acc;
    logic [5:0] pre_en;
    logic [5:0] data_en;
    logic [5:0] pre_err;
    logic [5:0] data_err;
    logic eof;
    logic timeout;
    logic fail;
    logic [7:0] rdata;
  } rsmt_state_t;

endpackage

// ### src/rsmt_regs.sv
`timescale 1ns/10ps
`include "rsmt_params.svh"
// How it works
// RULE1: Bit 7 of preamble control extends the search timeout into preamble.
// RULE2: Preamble monitors active exactly per preamble enables, bits 6..1.
// RULE3: Preamble accumulate bit makes error indicators collect over the phase.
// RULE4: Preamble accumulator clears at phase start and on status sample.
// RULE5: Data monitors active exactly per data enables, bits 6..1.
// RULE6: Any enabled data monitor fault raises the end-of-frame flag.
// RULE7: Data accumulate bit collects error indicators over data reception.
// RULE8: Data accumulator clears at reception start and on status sample.
// RULE9: Prescaler codes 0..3 give tick periods of 2, 4, 16, 64 bits.
// RULE10: Count 1..63 ends the search after that many ticks.
// RULE11: Count zero disables the timer, search never times out.
// RULE12: Acquired slicer threshold low byte loads register 32h.
// RULE13: Acquired slicer threshold high byte loads register 33h.
// RULE14: Host can read back the slicer initialisation value.
// RULE15: Host writes restore a saved threshold used for initialisation.
// RULE16: Stored init value stays apart from the drifting live threshold.
// RULE17: Enable bits 6..1: chip timeout, timing, coding, baud, RSSI, amplitude.
// RULE18: Optimistic search fails when timer expires before all monitors pass.
// RULE19: Timer restarts at each search or extended preamble, stops at end.
// RULE20: Data control bit 7 reads zero and ignores writes.
module rsmt_regs #(
  parameter int SLICER_W = 16
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire rsmt_pkg::rsmt_regreq_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire rsmt_pkg::rsmt_phase_t phase_i,
  input wire logic bit_tick_i,
  input wire logic search_pass_policy_i,
  input wire logic status_sample_i,
  input wire rsmt_pkg::rsmt_mon_t mon_i,
  input wire logic slicer_acq_valid_i,
  input wire logic [15:0] slicer_acq_value_i,
  output logic [5:0] preamble_monitor_enables_o,
  output logic [5:0] data_monitor_enables_o,
  output logic [5:0] preamble_error_o,
  output logic [5:0] data_error_o,
  output logic eof_flag_o,
  output logic search_timeout_o,
  output logic search_fail_o,
  output logic [15:0] slicer_init_value_o,
  output logic [7:0] timing_check_ctrl_o
);
  import rsmt_pkg::*;

  // Refuse slicer widths outside 9 to 16 bits, the range that spans both byte registers
  generate
    if (SLICER_W < 9 || SLICER_W > 16) begin : g_bad_width
      $error("SLICER_W must lie between 9 and 16");
    end
  endgenerate

  localparam logic [15:0] SL_MASK = 16'((32'h1 << SLICER_W) - 32'h1);

  rsmt_state_t st;
  rsmt_state_t next_st;

  // Tick period in bit periods for a prescaler code
  function automatic logic [6:0] tick_period(input logic [1:0] code);
    logic [6:0] p;
    p = `RSMT_TICK_P0;
    case (code)
      `RSMT_PC_2: p = `RSMT_TICK_P0;
      `RSMT_PC_4: p = `RSMT_TICK_P1;
      `RSMT_PC_16: p = `RSMT_TICK_P2;
      `RSMT_PC_64: p = `RSMT_TICK_P3;
      default: p = `RSMT_TICK_P0;
    endcase
    return p;
  endfunction

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic [5:0] pre_sel;
  logic [5:0] data_sel;
  logic [5:0] cur_pre;
  logic [5:0] cur_data;
  logic pre_start;
  logic data_start;
  logic timer_run;
  logic phase_start;
  logic [5:0] tmo_cnt;
  logic [6:0] period;

  // Phase entry detection and monitor gating
  always_comb begin
    pre_sel = st.pre_ctrl[`RSMT_EN_HI:`RSMT_EN_LO];
    data_sel = st.data_ctrl[`RSMT_EN_HI:`RSMT_EN_LO];
    phase_start = phase_i != st.phase_q;
    pre_start = phase_i == RSMT_PRE && st.phase_q != RSMT_PRE;
    data_start = phase_i == RSMT_DATA && st.phase_q != RSMT_DATA;
    cur_pre = mon_i.fail & pre_sel & {6{phase_i == RSMT_PRE}}; // RULE2
    cur_data = mon_i.fail & data_sel & {6{phase_i == RSMT_DATA}}; // RULE5
    timer_run = phase_i == RSMT_WAKE ||
                (phase_i == RSMT_PRE && st.pre_ctrl[`RSMT_BIT_EXT]); // RULE1
    tmo_cnt = st.tmo_ctrl[`RSMT_CNT_HI:`RSMT_CNT_LO];
    period = tick_period(st.tmo_ctrl[`RSMT_PRESC_HI:`RSMT_PRESC_LO]); // RULE9
  end

  // Next state of registers, timer, accumulators and outputs
  always_comb begin
    next_st = st;
    next_st.phase_q = phase_i;
    next_st.timeout = 1'b0;
    next_st.fail = 1'b0;

    // Register writes; data control bit 7 is forced to zero
    if (reg_req_i.wr) begin
      if (hit(reg_req_i.addr, `RSMT_OFS_PRE)) begin
        next_st.pre_ctrl = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_DATA)) begin
        next_st.data_ctrl = reg_req_i.wdata;
        next_st.data_ctrl[`RSMT_BIT_RSVD] = 1'b0; // RULE20
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_TMO)) begin
        next_st.tmo_ctrl = reg_req_i.wdata;
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_SLL)) begin
        next_st.slicer[`RSMT_SL_LO:0] = reg_req_i.wdata; // RULE15
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_SLH)) begin
        next_st.slicer[`RSMT_SL_HI:`RSMT_SL_MID] = reg_req_i.wdata; // RULE15
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_TCHK)) begin
        next_st.tchk = reg_req_i.wdata;
      end
    end

    // Acquisition result overrides a host write in the same cycle
    if (slicer_acq_valid_i) begin
      next_st.slicer = slicer_acq_value_i; // RULE12 RULE13
    end
    next_st.slicer = next_st.slicer & SL_MASK; // RULE16

    // Search timeout timer, restarted on every phase entry
    if (phase_start || !timer_run) begin
      next_st.presc_cnt = 7'h00; // RULE19
      next_st.tick_cnt = 6'h00;
      next_st.timer_done = 1'b0;
    end else if (tmo_cnt != 6'h00 && // RULE11
                 !st.timer_done && bit_tick_i) begin
      if (st.presc_cnt + 7'h01 >= period) begin
        next_st.presc_cnt = 7'h00;
        next_st.tick_cnt = st.tick_cnt + 6'h01;
        if (st.tick_cnt + 6'h01 >= tmo_cnt) begin
          next_st.timeout = 1'b1; // RULE10
          next_st.timer_done = 1'b1;
          next_st.fail = search_pass_policy_i && !mon_i.all_pass; // RULE18
        end
      end else begin
        next_st.presc_cnt = st.presc_cnt + 7'h01;
      end
    end

    // Error accumulators; a fault in the clearing cycle is kept
    if (pre_start || status_sample_i) begin
      next_st.pre_acc = cur_pre; // RULE4
    end else begin
      next_st.pre_acc = st.pre_acc | cur_pre;
    end
    if (data_start || status_sample_i) begin
      next_st.data_acc = cur_data; // RULE8
    end else begin
      next_st.data_acc = st.data_acc | cur_data;
    end
    next_st.pre_err = st.pre_ctrl[`RSMT_BIT_ACC] ?
                      next_st.pre_acc : cur_pre; // RULE3
    next_st.data_err = st.data_ctrl[`RSMT_BIT_ACC] ?
                       next_st.data_acc : cur_data; // RULE7

    // Monitor enables presented only in their own phase
    next_st.pre_en = pre_sel & {6{phase_i == RSMT_PRE}}; // RULE17
    next_st.data_en = data_sel & {6{phase_i == RSMT_DATA}}; // RULE17
    next_st.eof = phase_i == RSMT_DATA && (|cur_data); // RULE6

    // Read data, held until the next read
    if (reg_req_i.rd) begin
      next_st.rdata = `RSMT_RD_NONE;
      if (hit(reg_req_i.addr, `RSMT_OFS_PRE)) begin
        next_st.rdata = st.pre_ctrl;
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_DATA)) begin
        next_st.rdata = st.data_ctrl;
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_TMO)) begin
        next_st.rdata = st.tmo_ctrl;
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_SLL)) begin
        next_st.rdata = st.slicer[`RSMT_SL_LO:0]; // RULE14
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_SLH)) begin
        next_st.rdata = st.slicer[`RSMT_SL_HI:`RSMT_SL_MID]; // RULE14
      end
      if (hit(reg_req_i.addr, `RSMT_OFS_TCHK)) begin
        next_st.rdata = st.tchk;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.pre_ctrl <= `RSMT_RST_BYTE;
      st.data_ctrl <= `RSMT_RST_BYTE;
      st.tmo_ctrl <= `RSMT_RST_BYTE;
      st.slicer <= `RSMT_RST_WORD;
      st.tchk <= `RSMT_RST_BYTE;
      st.phase_q <= RSMT_IDLE;
      st.presc_cnt <= 7'h00;
      st.tick_cnt <= 6'h00;
      st.timer_done <= 1'b0;
      st.pre_acc <= 6'h00;
      st.data_acc <= 6'h00;
      st.pre_en <= 6'h00;
      st.data_en <= 6'h00;
      st.pre_err <= 6'h00;
      st.data_err <= 6'h00;
      st.eof <= 1'b0;
      st.timeout <= 1'b0;
      st.fail <= 1'b0;
      st.rdata <= `RSMT_RD_NONE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = st.rdata;
  assign preamble_monitor_enables_o = st.pre_en;
  assign data_monitor_enables_o = st.data_en;
  assign preamble_error_o = st.pre_err;
  assign data_error_o = st.data_err;
  assign eof_flag_o = st.eof;
  assign search_timeout_o = st.timeout;
  assign search_fail_o = st.fail;
  assign slicer_init_value_o = st.slicer;
  assign timing_check_ctrl_o = st.tchk;

  // Helper: bit ticks seen since the timed phase began
  logic [12:0] chk_ticks;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chk_ticks <= 13'h0000;
    end else if (phase_start || !timer_run) begin
      chk_ticks <= 13'h0000;
    end else if (bit_tick_i) begin
      chk_ticks <= chk_ticks + 13'h0001;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_pre_enable_gate: assert property ( // RULE2
    phase_i != RSMT_PRE |=> preamble_monitor_enables_o == 6'h00)
    else $error("preamble enables active outside preamble");
  a_data_enable_gate: assert property ( // RULE5
    phase_i == RSMT_DATA |=>
      data_monitor_enables_o == $past(data_sel))
    else $error("data enables differ from control bits");
  a_data_bit7_zero: assert property ( // RULE20
    reg_req_i.wr && reg_req_i.addr == `RSMT_OFS_DATA |=>
      st.data_ctrl[`RSMT_BIT_RSVD] == 1'b0)
    else $error("data control bit 7 took a write");
  a_zero_count_idle: assert property ( // RULE11
    tmo_cnt == 6'h00 |=> !search_timeout_o)
    else $error("timeout with zero count");
  a_timeout_length: assert property ( // RULE9 RULE10
    search_timeout_o |->
      chk_ticks == 13'(tmo_cnt) * 13'(period))
    else $error("timeout after wrong number of bit periods");
  a_ext_phase_only: assert property ( // RULE1
    search_timeout_o |-> $past(timer_run))
    else $error("timeout outside wakeup or extended preamble");
  a_fail_policy: assert property ( // RULE18
    search_fail_o |-> search_timeout_o && $past(search_pass_policy_i))
    else $error("search fail without optimistic timeout");
  a_pre_acc_clear: assert property ( // RULE4
    pre_start |=> st.pre_acc == $past(cur_pre))
    else $error("preamble accumulator not cleared at start");
  a_data_acc_clear: assert property ( // RULE8
    status_sample_i && !data_start |=> st.data_acc == $past(cur_data))
    else $error("data accumulator not cleared on sample");
  a_pre_accum_keep: assert property ( // RULE3
    phase_i == RSMT_PRE && st.phase_q == RSMT_PRE &&
      st.pre_ctrl[`RSMT_BIT_ACC] && !status_sample_i |=>
      (preamble_error_o & $past(preamble_error_o)) ==
        $past(preamble_error_o))
    else $error("preamble error indicator lost while accumulating");
  a_eof_raise: assert property ( // RULE6
    phase_i == RSMT_DATA && (|cur_data) |=> eof_flag_o)
    else $error("monitor fault did not raise end of frame");
  a_slicer_acq: assert property ( // RULE12
    slicer_acq_valid_i |=>
      slicer_init_value_o == ($past(slicer_acq_value_i) & SL_MASK))
    else $error("acquired threshold not stored");
  a_slicer_restore: assert property ( // RULE15
    reg_req_i.wr && reg_req_i.addr == `RSMT_OFS_SLL &&
      !slicer_acq_valid_i |=>
      slicer_init_value_o[`RSMT_SL_LO:0] == $past(reg_req_i.wdata))
    else $error("host slicer write not taken");

  // Guards on data accumulation, slicer write and readback, restart, current errors and quiet outputs
  a_data_accum_keep: assert property ( // RULE7
    phase_i == RSMT_DATA && st.phase_q == RSMT_DATA &&
      st.data_ctrl[`RSMT_BIT_ACC] && !status_sample_i |=>
      (data_error_o & $past(data_error_o)) == $past(data_error_o))
    else $error("data error indicator lost while accumulating");
  a_slicer_high_wr: assert property ( // RULE15
    reg_req_i.wr && reg_req_i.addr == `RSMT_OFS_SLH &&
      !slicer_acq_valid_i |=>
      slicer_init_value_o[`RSMT_SL_HI:`RSMT_SL_MID] == $past(reg_req_i.wdata))
    else $error("host slicer high write not taken");
  a_slicer_readback: assert property ( // RULE14
    reg_req_i.rd && reg_req_i.addr == `RSMT_OFS_SLH |=>
      reg_rdata_o == $past(slicer_init_value_o[`RSMT_SL_HI:`RSMT_SL_MID]))
    else $error("slicer high byte read back wrong");
  a_timer_restart: assert property ( // RULE19
    phase_start |=> st.tick_cnt == 6'h00 && st.presc_cnt == 7'h00)
    else $error("timeout timer not restarted on phase entry");
  a_pre_err_current: assert property ( // RULE3
    !st.pre_ctrl[`RSMT_BIT_ACC] |=> preamble_error_o == $past(cur_pre))
    else $error("preamble error not current without accumulate");
  a_eof_quiet: assert property ( // RULE6
    phase_i != RSMT_DATA |=> !eof_flag_o)
    else $error("end of frame outside data reception");

  c_timeout_seen: cover property (search_timeout_o);
  c_optimistic_fail: cover property (search_fail_o);
  c_eof_raised: cover property (eof_flag_o);
  c_slicer_read: cover property (
    reg_req_i.rd && reg_req_i.addr == `RSMT_OFS_SLH);
  c_pre_accum: cover property (
    st.pre_ctrl[`RSMT_BIT_ACC] && preamble_error_o != 6'h00);

endmodule

// ### dv/rsmt_host_model.sv
`timescale 1ns/10ps
module rsmt_host_model (
  input wire logic mclk_i,
  output rsmt_pkg::rsmt_regreq_t req_o,
  input wire logic [7:0] rdata_i
);
  import rsmt_pkg::*;
  // Idle register port from time zero
  initial begin
    req_o = '0;
  end
  // Write strobe held for one edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    req_o.wr <= 1'b0;
  endtask
  // Read strobe, data settles after the next edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req_o.rd <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule

// ### dv/rsmt_regs_bench.sv
`timescale 1ns/10ps
`include "rsmt_params.svh"
module rsmt_regs_bench;
  import rsmt_pkg::*;
  logic mclk_i, resetn_i, bit_tick_i, search_pass_policy_i;
  logic status_sample_i, slicer_acq_valid_i;
  logic [15:0] slicer_acq_value_i, slicer_init_value_o;
  rsmt_regreq_t reg_req_i;
  rsmt_phase_t phase_i;
  rsmt_mon_t mon_i;
  logic [7:0] reg_rdata_o, timing_check_ctrl_o, rd;
  logic [5:0] pre_en, data_en, pre_err, data_err;
  logic eof_flag_o, search_timeout_o, search_fail_o;
  int mismatches = 0;
  int checks = 0;
  // Rows: address, written byte, expected readback
  logic [7:0] rows [7][3] = '{'{8'h2F, 8'hA5, 8'hA5},
    '{8'h30, 8'hFF, 8'h7F}, '{8'h31, 8'hC5, 8'hC5},
    '{8'h32, 8'h5A, 8'h5A}, '{8'h33, 8'hC3, 8'hC3},
    '{8'h34, 8'h3C, 8'h3C}, '{8'h35, 8'hFF, 8'h00}};

  rsmt_regs rsmt_regs_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .phase_i(phase_i),
    .bit_tick_i(bit_tick_i), .search_pass_policy_i(search_pass_policy_i),
    .status_sample_i(status_sample_i), .mon_i(mon_i),
    .slicer_acq_valid_i(slicer_acq_valid_i),
    .slicer_acq_value_i(slicer_acq_value_i),
    .preamble_monitor_enables_o(pre_en), .data_monitor_enables_o(data_en),
    .preamble_error_o(pre_err), .data_error_o(data_err),
    .eof_flag_o(eof_flag_o), .search_timeout_o(search_timeout_o),
    .search_fail_o(search_fail_o), .slicer_init_value_o(slicer_init_value_o),
    .timing_check_ctrl_o(timing_check_ctrl_o));

  rsmt_host_model rsmt_host_model_inst (.mclk_i(mclk_i), .req_o(reg_req_i),
    .rdata_i(reg_rdata_o));

  // Free running clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle monitor fault, outputs sampled after it lands
  task automatic fault(input logic [5:0] f);
    @(posedge mclk_i);
    mon_i.fail <= f;
    @(posedge mclk_i);
    mon_i.fail <= 6'h00;
    #1;
  endtask

  // Host status sample pulse
  task automatic sample;
    @(posedge mclk_i);
    status_sample_i <= 1'b1;
    @(posedge mclk_i);
    status_sample_i <= 1'b0;
    #1;
  endtask

  // Run the search timer; exp_n 0 means no timeout in 300 cycles
  task automatic timer_run(input logic [7:0] tmo, input rsmt_phase_t ph,
                           input int exp_n, input logic pass);
    int n;
    n = 0;
    rsmt_host_model_inst.write(`RSMT_OFS_TMO, tmo);
    @(posedge mclk_i);
    phase_i <= ph;
    mon_i.all_pass <= pass;
    @(posedge mclk_i);
    bit_tick_i <= 1'b1;
    while (n < 300 && search_timeout_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk((n == 300) ? 16'h0000 : 16'(n), 16'(exp_n), "timeout cycles");
    if (n < 300 && ph == RSMT_WAKE) begin
      chk(16'(search_fail_o), 16'(!pass), "search fail");
    end
    @(posedge mclk_i);
    bit_tick_i <= 1'b0;
    phase_i <= RSMT_IDLE;
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial begin
    resetn_i = 1'b0;
    phase_i = RSMT_IDLE;
    bit_tick_i = 1'b0;
    search_pass_policy_i = 1'b1;
    status_sample_i = 1'b0;
    mon_i = '0;
    slicer_acq_valid_i = 1'b0;
    slicer_acq_value_i = 16'h0000;
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    // Reset values, then write and read back each row
    foreach (rows[i]) begin
      rsmt_host_model_inst.read(rows[i][0], rd);
      chk(16'(rd), 16'h0000, "reset value");
      rsmt_host_model_inst.write(rows[i][0], rows[i][1]);
      rsmt_host_model_inst.read(rows[i][0], rd);
      chk(16'(rd), 16'(rows[i][2]), "readback");
    end
    chk(slicer_init_value_o, 16'hC35A, "restored slicer");
    chk(16'(timing_check_ctrl_o), 16'h003C, "timing check");
    // Acquired threshold lands in both slicer bytes
    @(posedge mclk_i);
    slicer_acq_valid_i <= 1'b1;
    slicer_acq_value_i <= 16'hBEEF;
    @(posedge mclk_i);
    slicer_acq_valid_i <= 1'b0;
    rsmt_host_model_inst.read(`RSMT_OFS_SLL, rd);
    chk(16'(rd), 16'h00EF, "slicer low");
    rsmt_host_model_inst.read(`RSMT_OFS_SLH, rd);
    chk(16'(rd), 16'h00BE, "slicer high");
    chk(slicer_init_value_o, 16'hBEEF, "slicer init");
    // Preamble monitors, current then accumulated errors
    rsmt_host_model_inst.write(`RSMT_OFS_PRE, 8'h7E);
    @(posedge mclk_i);
    phase_i <= RSMT_PRE;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(16'(pre_en), 16'h003F, "preamble enables");
    chk(16'(data_en), 16'h0000, "data enables off");
    fault(6'h20);
    chk(16'(pre_err), 16'h0020, "preamble error");
    @(posedge mclk_i);
    #1;
    chk(16'(pre_err), 16'h0000, "preamble current");
    rsmt_host_model_inst.write(`RSMT_OFS_PRE, 8'h7F);
    fault(6'h01);
    @(posedge mclk_i);
    #1;
    chk(16'(pre_err), 16'h0021, "preamble accumulated");
    sample();
    chk(16'(pre_err), 16'h0000, "preamble cleared");
    // Data reception with amplitude monitor only
    rsmt_host_model_inst.write(`RSMT_OFS_DATA, 8'h03);
    @(posedge mclk_i);
    phase_i <= RSMT_DATA;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(16'(data_en), 16'h0001, "data enables");
    chk(16'(pre_en), 16'h0000, "preamble enables off");
    fault(6'h01);
    chk(16'(eof_flag_o), 16'h0001, "end of frame");
    @(posedge mclk_i);
    #1;
    chk(16'(data_err), 16'h0001, "data accumulated");
    fault(6'h08);
    chk(16'(eof_flag_o), 16'h0000, "disabled monitor");
    sample();
    chk(16'(data_err), 16'h0000, "data cleared");
    @(posedge mclk_i);
    phase_i <= RSMT_IDLE;
    // Timer, every prescaler code, disable and preamble extension
    timer_run(8'h3F, RSMT_WAKE, 126, 1'b0);
    timer_run(8'h45, RSMT_WAKE, 20, 1'b0);
    timer_run(8'h82, RSMT_WAKE, 32, 1'b1);
    timer_run(8'hC1, RSMT_WAKE, 64, 1'b0);
    timer_run(8'h00, RSMT_WAKE, 0, 1'b0);
    rsmt_host_model_inst.write(`RSMT_OFS_PRE, 8'h80);
    timer_run(8'h01, RSMT_PRE, 2, 1'b0);
    rsmt_host_model_inst.write(`RSMT_OFS_PRE, 8'h00);
    timer_run(8'h01, RSMT_PRE, 0, 1'b0);
    stop_test();
  end
endmodule
